// file: design/cfbp_defs.svh
// Offsets, field width, reset values and codes of the filter pointer block
`ifndef CFBP_DEFS_SVH
`define CFBP_DEFS_SVH
`define CFBP_OFF_DEST_8_11   12'h000
`define CFBP_OFF_DEST_12_15  12'h004
`define CFBP_OFF_HIT_STATUS  12'h008
`define CFBP_RESET_DEST      16'h0000
`define CFBP_FIELD_W         4
`define CFBP_CODE_FIFO       4'hf
`define CFBP_FIRST_FILTER    4'h8
`define CFBP_RESP_OKAY       2'b00
`define CFBP_RESP_SLVERR     2'b10
`endif

// file: design/cfbp_pkg.sv
// Types of the filter pointer block
package cfbp_pkg;
  typedef logic [3:0] cfbp_ptr_t;
  typedef logic [15:0] cfbp_word_t;
  typedef enum logic [1:0]
  {
    CFBP_W_IDLE = 2'b00,
    CFBP_W_RESP = 2'b01
  } cfbp_wstate_e;
endpackage

// file: design/cfbp_dest_regs.sv
// Two filter destination registers, 16 bits each, read data registered
`timescale 1ns/1ps
`include "cfbp_defs.svh"
module cfbp_dest_regs
  import cfbp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       wrEn,
  input  wire logic       wrSel,
  input  wire cfbp_word_t wrData,
  input  wire logic [1:0] wrStrb,
  input  wire logic       rdSel,
  output cfbp_word_t      rdData,
  output cfbp_word_t      dest8to11,
  output cfbp_word_t      dest12to15
);
  cfbp_word_t mem [2];
  cfbp_word_t next_mem [2];
  cfbp_word_t next_rdData;

  // Byte-lane merge of the write
  always_comb
  begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    for (int i = 0; i < 2; i++)
    begin
      if (wrEn && wrStrb[i])
      begin
        next_mem[wrSel][i*8 +: 8] = wrData[i*8 +: 8]; // (R5)
      end
    end
    next_rdData = next_mem[rdSel];
  end

  // Storage clears to zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mem[0] <= `CFBP_RESET_DEST; // (R4)
      mem[1] <= `CFBP_RESET_DEST; // (R4)
      rdData <= `CFBP_RESET_DEST;
    end
    else
    begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      rdData <= next_rdData;
    end
  end

  assign dest8to11  = mem[0]; // (R1)
  assign dest12to15 = mem[1]; // (R2)
endmodule

// file: design/can_filter_buffer_pointers.sv
// CAN receive filter destination pointers for filters 8 to 15 with AXI4-Lite
//
// Behaviour
// (R1) Register one: filters 8-11, four nibbles
// (R2) Register two: filters 12-15, four nibbles
// (R3) Codes 0-14 select receive buffer index
// (R4) All pointer bits clear to zero
// (R5) Software reads back what it wrote
// (R6) Code 1111 selects the receive FIFO
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "cfbp_defs.svh"
module can_filter_buffer_pointers
  import cfbp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        filterHit,
  input  wire logic [3:0]  filterHitIndex,
  output logic             destValid,
  output logic             destToFifo,
  output logic [3:0]       destBufferIndex
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by read and write
  function automatic logic [1:0] decode(input logic [11:0] addr);
    unique case (addr)
      `CFBP_OFF_DEST_8_11:  decode = 2'h1;
      `CFBP_OFF_DEST_12_15: decode = 2'h2;
      `CFBP_OFF_HIT_STATUS: decode = 2'h3;
      default:              decode = 2'h0;
    endcase
  endfunction

  // Pick one filter's nibble; index 8-15 only
  function automatic cfbp_ptr_t pickPtr(input cfbp_word_t lo, input cfbp_word_t hi,
                                        input logic [3:0] idx);
    cfbp_word_t w;
    w = idx[2] ? hi : lo;
    pickPtr = w[idx[1:0]*`CFBP_FIELD_W +: `CFBP_FIELD_W];
  endfunction

  cfbp_wstate_e wState;
  cfbp_wstate_e next_wState;
  logic         awHeld;
  logic         next_awHeld;
  logic [11:0]  awAddr;
  logic [11:0]  next_awAddr;
  logic         wHeld;
  logic         next_wHeld;
  logic [31:0]  wData;
  logic [31:0]  next_wData;
  logic [3:0]   wStrb;
  logic [3:0]   next_wStrb;
  logic [1:0]   next_bresp;
  logic         next_bvalid;
  logic         rBusy;
  logic         next_rBusy;
  logic         rPend;
  logic         next_rPend;
  logic [1:0]   rKind;
  logic [1:0]   next_rKind;
  logic [1:0]   wKind;
  logic         regWrEn;
  logic         regWrSel;
  logic         regRdSel;
  cfbp_word_t   regRdData;
  cfbp_word_t   dest8to11;
  cfbp_word_t   dest12to15;
  logic [31:0]  next_rdata;
  logic [1:0]   next_rresp;
  logic         next_rvalid;
  logic         next_destValid;
  logic         next_destToFifo;
  logic [3:0]   next_destBufferIndex;
  cfbp_ptr_t    hitPtr;
  logic [3:0]   lastHit;
  logic [3:0]   next_lastHit;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, then one response
  always_comb
  begin
    next_wState = wState;
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bresp  = s_axi_bresp;
    next_bvalid = s_axi_bvalid;
    regWrEn     = 1'b0;
    wKind       = decode(awAddr);
    unique case (wState)
      CFBP_W_IDLE:
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          next_awHeld = 1'b1;
          next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          next_wHeld = 1'b1;
          next_wData = s_axi_wdata;
          next_wStrb = s_axi_wstrb;
        end
        // Commit one cycle after both halves are held
        if (awHeld && wHeld)
        begin
          regWrEn     = (wKind == 2'h1) || (wKind == 2'h2); // (R5)
          next_bresp  = (wKind == 2'h0) ? `CFBP_RESP_SLVERR : `CFBP_RESP_OKAY;
          next_bvalid = 1'b1;
          next_awHeld = 1'b0;
          next_wHeld  = 1'b0;
          next_wState = CFBP_W_RESP;
        end
      end
      CFBP_W_RESP:
      begin
        if (s_axi_bready)
        begin
          next_bvalid = 1'b0;
          next_wState = CFBP_W_IDLE;
        end
      end
    endcase
  end
  assign regWrSel = (wKind == 2'h2);

  // Write channel state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wState        <= CFBP_W_IDLE;
      awHeld        <= 1'b0;
      awAddr        <= 12'h000;
      wHeld         <= 1'b0;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      s_axi_bresp   <= `CFBP_RESP_OKAY;
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      wState        <= next_wState;
      awHeld        <= next_awHeld;
      awAddr        <= next_awAddr;
      wHeld         <= next_wHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      s_axi_bresp   <= next_bresp;
      s_axi_bvalid  <= next_bvalid;
      // Ready only while that half is empty, so no second beat slips in
      s_axi_awready <= (next_wState == CFBP_W_IDLE) && !next_awHeld
                       && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= (next_wState == CFBP_W_IDLE) && !next_wHeld
                       && !(s_axi_wvalid && s_axi_wready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: address taken, storage read registered, then data
  always_comb
  begin
    next_rBusy  = rBusy;
    next_rPend  = 1'b0;
    next_rKind  = rKind;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rBusy = 1'b1;
      next_rPend = 1'b1;
      next_rKind = decode(s_axi_araddr);
    end
    if (rPend)
    begin
      next_rvalid = 1'b1;
      next_rresp  = (rKind == 2'h0) ? `CFBP_RESP_SLVERR : `CFBP_RESP_OKAY;
      unique case (rKind)
        2'h1, 2'h2: next_rdata = {16'h0000, regRdData}; // (R5)
        2'h3:       next_rdata = {27'h0000000, destToFifo, lastHit};
        default:    next_rdata = 32'h00000000;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
      next_rBusy  = 1'b0;
    end
  end
  assign regRdSel = (decode(s_axi_araddr) == 2'h2);

  // Read channel state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rBusy         <= 1'b0;
      rPend         <= 1'b0;
      rKind         <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CFBP_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      rBusy         <= next_rBusy;
      rPend         <= next_rPend;
      rKind         <= next_rKind;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= !next_rBusy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage; read port sampled at the address handshake
  cfbp_dest_regs u_regs
  (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .wrEn       (regWrEn),
    .wrSel      (regWrSel),
    .wrData     (wData[15:0]),
    .wrStrb     (wStrb[1:0]),
    .rdSel      (regRdSel),
    .rdData     (regRdData),
    .dest8to11  (dest8to11),
    .dest12to15 (dest12to15)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Hit steering: filters below 8 belong elsewhere and are ignored
  assign hitPtr = pickPtr(dest8to11, dest12to15, filterHitIndex);
  always_comb
  begin
    next_destValid       = filterHit && filterHitIndex[3];
    next_destToFifo      = destToFifo;
    next_destBufferIndex = destBufferIndex;
    next_lastHit         = lastHit;
    if (next_destValid)
    begin
      next_destToFifo      = (hitPtr == `CFBP_CODE_FIFO); // (R6)
      next_destBufferIndex = hitPtr; // (R3)
      next_lastHit         = filterHitIndex;
    end
  end

  // Destination outputs registered
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      destValid       <= 1'b0;
      destToFifo      <= 1'b0;
      destBufferIndex <= 4'h0;
      lastHit         <= 4'h0;
    end
    else
    begin
      destValid       <= next_destValid;
      destToFifo      <= next_destToFifo;
      destBufferIndex <= next_destBufferIndex;
      lastHit         <= next_lastHit;
    end
  end
endmodule

// file: dv/cfbp_props.sv
// Concurrent checks on the filter pointer block ports
`timescale 1ns/1ps
module cfbp_props
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        filterHit,
  input wire logic [3:0]  filterHitIndex,
  input wire logic        destValid,
  input wire logic        destToFifo,
  input wire logic [3:0]  destBufferIndex
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Hit port: only filters 8 to 15 answer, one cycle later
  property p_hit;
    filterHit && filterHitIndex >= 4'h8 |=> destValid;
  endproperty
  a_hit: assert property (p_hit) else $error("no answer to hit");
  property p_noHit;
    !(filterHit && filterHitIndex >= 4'h8) |=> !destValid;
  endproperty
  a_noHit: assert property (p_noHit) else $error("answer without hit");
  property p_fifo;
    destValid |-> destToFifo == (destBufferIndex == 4'hf);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo flag wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Register bus timing and data width
  property p_bLat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_bLat: assert property (p_bLat) else $error("write answer late");
  property p_rLat;
    s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rLat: assert property (p_rLat) else $error("read answer late");
  property p_bDrop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bDrop: assert property (p_bDrop) else $error("bvalid stuck");
  property p_arBusy;
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready;
  endproperty
  a_arBusy: assert property (p_arBusy) else $error("second read taken");
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
endmodule
bind can_filter_buffer_pointers cfbp_props u_props
(
  .clk_sys         (clk_sys),
  .rst             (rst),
  .s_axi_awvalid   (s_axi_awvalid),
  .s_axi_awready   (s_axi_awready),
  .s_axi_wvalid    (s_axi_wvalid),
  .s_axi_wready    (s_axi_wready),
  .s_axi_bvalid    (s_axi_bvalid),
  .s_axi_bready    (s_axi_bready),
  .s_axi_arvalid   (s_axi_arvalid),
  .s_axi_arready   (s_axi_arready),
  .s_axi_rvalid    (s_axi_rvalid),
  .s_axi_rready    (s_axi_rready),
  .s_axi_rdata     (s_axi_rdata),
  .filterHit       (filterHit),
  .filterHitIndex  (filterHitIndex),
  .destValid       (destValid),
  .destToFifo      (destToFifo),
  .destBufferIndex (destBufferIndex)
);

// file: dv/can_filter_buffer_pointers_tb_top.sv
// Self-checking bench for the filter pointer block
`timescale 1ns/1ps
`include "cfbp_defs.svh"
module can_filter_buffer_pointers_tb_top;
  logic clk_sys = 0, rst = 1, filterHit = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, destValid, destToFifo;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h3, filterHitIndex = 0, destBufferIndex;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] r0, r1, code;
  int num_errors = 0, samples_checked = 0;
  // Two pattern pairs, second is the bitwise inverse of the first
  logic [15:0] pat [4] = '{16'h3f1e, 16'hf0a5, 16'hc0e1, 16'h0f5a};
  can_filter_buffer_pointers uut
  (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .s_axi_awaddr    (s_axi_awaddr),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wdata     (s_axi_wdata),
    .s_axi_wstrb     (s_axi_wstrb),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_araddr    (s_axi_araddr),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rresp     (s_axi_rresp),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready),
    .filterHit       (filterHit),
    .filterHitIndex  (filterHitIndex),
    .destValid       (destValid),
    .destToFifo      (destToFifo),
    .destBufferIndex (destBufferIndex)
  );
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // Compare and report helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50)
    begin
      num_errors++;
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles; both hold each channel until its own ready
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(s_axi_bresp, er);
    // One idle edge so the next call never re-raises bready in this step
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    tmo(n);
    // Data and response apart; one word cannot hold both
    chk(s_axi_rdata, {16'h0000, ed});
    chk(s_axi_rresp, er);
    @(posedge clk_sys);
  endtask
  // One hit pulse; result is looked at once the answering edge has landed
  task automatic hit(input logic [3:0] i, input logic [5:0] e);
    filterHit <= 1'b1;
    filterHitIndex <= i;
    @(posedge clk_sys);
    filterHit <= 1'b0;
    #1;
    chk({destValid, destToFifo, destBufferIndex}, e);
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`CFBP_OFF_DEST_8_11, 16'h0000, `CFBP_RESP_OKAY);
    rd(`CFBP_OFF_DEST_12_15, 16'h0000, `CFBP_RESP_OKAY);
    hit(4'hb, 6'h20);
    for (int s = 0; s < 4; s += 2)
    begin
      r0 = pat[s];
      r1 = pat[s+1];
      wr(`CFBP_OFF_DEST_8_11, r0, `CFBP_RESP_OKAY);
      wr(`CFBP_OFF_DEST_12_15, r1, `CFBP_RESP_OKAY);
      rd(`CFBP_OFF_DEST_8_11, r0, `CFBP_RESP_OKAY);
      rd(`CFBP_OFF_DEST_12_15, r1, `CFBP_RESP_OKAY);
      for (int i = 8; i < 16; i++)
      begin
        code = (i < 12) ? r0 >> (4 * (i - 8)) : r1 >> (4 * (i - 12));
        hit(i[3:0], {1'b1, code[3:0] == 4'hf, code[3:0]});
      end
      hit(4'h3, {1'b0, code[3:0] == 4'hf, code[3:0]});
      // Status keeps filter 15 as last accepted; the ignored hit leaves it
      rd(`CFBP_OFF_HIT_STATUS, {11'h0, code[3:0] == 4'hf, 4'hf}, `CFBP_RESP_OKAY);
    end
    // Unmapped place: write dropped, read empty, both refused
    wr(12'h00c, 16'hffff, `CFBP_RESP_SLVERR);
    rd(12'h00c, 16'h0000, `CFBP_RESP_SLVERR);
    // Status place accepts a write and ignores it
    wr(`CFBP_OFF_HIT_STATUS, 16'hffff, `CFBP_RESP_OKAY);
    // Low lane only: the upper byte must survive the write
    s_axi_wstrb <= 4'h1;
    wr(`CFBP_OFF_DEST_8_11, 16'hffff, `CFBP_RESP_OKAY);
    s_axi_wstrb <= 4'h3;
    rd(`CFBP_OFF_DEST_8_11, {pat[2][15:8], 8'hff}, `CFBP_RESP_OKAY);
    rd(`CFBP_OFF_DEST_12_15, pat[3], `CFBP_RESP_OKAY);
    hit(4'h8, 6'h3f);
    summarize();
  end
endmodule
